// file: core/twe_ctl.sv
// Two-wire controller end: byte-level engine driven from a small register port.
// Assumes software sequences start, bytes and stop; the data line is synchronised.
`timescale 1ns/100ps

module twe_ctl #(
  parameter int unsigned QTR_CYC = twe_pkg::QTR_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link
  twe_if.ctl link,
  // Register port
  input wire logic [1:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o
);

  localparam int unsigned DW = $clog2(QTR_CYC + 1);

  if (QTR_CYC < 4) begin : g_chk
    $error("QTR_CYC too small for the target to see every edge");
  end

  typedef enum logic [3:0] {
    C_IDLE = 4'h1,
    C_START = 4'h2,
    C_STOP = 4'h4,
    C_BYTE = 4'h8
  } twe_cst_e;

  // ----------------------------------------------------------------
  // Data line synchroniser
  // ----------------------------------------------------------------
  logic [1:0] sda_s_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_s_r <= 2'h3;
    end else begin
      sda_s_r <= {sda_s_r[0], link.sda};
    end
  end

  // ----------------------------------------------------------------
  // Bit engine
  // ----------------------------------------------------------------
  twe_cst_e st_r, st_nxt;
  logic [DW-1:0] div_r, div_nxt;
  logic [1:0] q_r, q_nxt;
  logic [3:0] b_r, b_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [7:0] rx_r, rx_nxt;
  logic rdop_r, rdop_nxt;
  logic ackout_r, ackout_nxt;
  logic got_ack_r, got_ack_nxt;
  logic scl_r, scl_nxt;
  logic oe_r, oe_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic tick;
  twe_pkg::twe_op_e op;

  assign tick = (div_r == DW'(QTR_CYC - 1));
  assign op = twe_pkg::twe_op_e'(wdata_i[twe_pkg::CMD_OP_LSB +: 2]);

  always_comb begin
    st_nxt = st_r;
    div_nxt = div_r;
    q_nxt = q_r;
    b_nxt = b_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    rdop_nxt = rdop_r;
    ackout_nxt = ackout_r;
    got_ack_nxt = got_ack_r;
    scl_nxt = scl_r;
    oe_nxt = oe_r;
    rdata_nxt = 16'h0000;
    if (rd_i && addr_i == twe_pkg::REG_STAT) begin
      rdata_nxt[7:0] = rx_r;
      rdata_nxt[twe_pkg::STAT_BUSY_BIT] = (st_r != C_IDLE);
      rdata_nxt[twe_pkg::STAT_ACK_BIT] = got_ack_r;
    end
    if (st_r == C_IDLE) begin
      // Commands arriving while busy are dropped; poll the busy bit first
      if (wr_i && addr_i == twe_pkg::REG_CMD) begin
        div_nxt = '0;
        q_nxt = 2'h0;
        b_nxt = 4'h0;
        tx_nxt = wdata_i[7:0];
        ackout_nxt = wdata_i[twe_pkg::CMD_ACK_BIT];
        rdop_nxt = (op == twe_pkg::OP_READ);
        unique case (op)
          twe_pkg::OP_START: st_nxt = C_START;
          twe_pkg::OP_STOP: st_nxt = C_STOP;
          twe_pkg::OP_WRITE: st_nxt = C_BYTE;
          twe_pkg::OP_READ: st_nxt = C_BYTE;
        endcase
      end
    end else begin
      div_nxt = DW'(div_r + 1'b1);
      if (tick) begin
        div_nxt = '0;
        q_nxt = q_r + 2'h1;
        unique case (st_r)
          C_START: begin
            // Release data low-clock, raise clock, then pull data
            unique case (q_r)
              2'h0: oe_nxt = 1'b0;
              2'h1: scl_nxt = 1'b1;
              2'h2: oe_nxt = 1'b1;
              2'h3: begin
                scl_nxt = 1'b0;
                st_nxt = C_IDLE;
              end
            endcase
          end
          C_STOP: begin
            unique case (q_r)
              2'h0: oe_nxt = 1'b1;
              2'h1: scl_nxt = 1'b1;
              2'h2: oe_nxt = 1'b0;
              2'h3: st_nxt = C_IDLE;
            endcase
          end
          default: begin
            unique case (q_r)
              2'h0: begin
                // Data set while clock low
                if (b_r == twe_pkg::BIT_ACK) begin
                  oe_nxt = rdop_r & ackout_r;
                end else begin
                  oe_nxt = ~rdop_r & ~tx_r[7];
                end
              end
              2'h1: scl_nxt = 1'b1;
              2'h2: begin
                if (b_r == twe_pkg::BIT_ACK) begin
                  if (!rdop_r) begin
                    got_ack_nxt = ~sda_s_r[1];
                  end
                end else if (rdop_r) begin
                  rx_nxt = {rx_r[6:0], sda_s_r[1]};
                end
              end
              2'h3: begin
                scl_nxt = 1'b0;
                tx_nxt = {tx_r[6:0], 1'b0};
                // A read with no ack gives the nine free clocks of recovery
                if (b_r == twe_pkg::BIT_ACK) begin
                  st_nxt = C_IDLE;
                  oe_nxt = 1'b0;
                end else begin
                  b_nxt = b_r + 4'h1;
                end
              end
            endcase
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= C_IDLE;
      div_r <= '0;
      q_r <= 2'h0;
      b_r <= 4'h0;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      rdop_r <= 1'b0;
      ackout_r <= 1'b0;
      got_ack_r <= 1'b0;
      scl_r <= 1'b1;
      oe_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      q_r <= q_nxt;
      b_r <= b_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      rdop_r <= rdop_nxt;
      ackout_r <= ackout_nxt;
      got_ack_r <= got_ack_nxt;
      scl_r <= scl_nxt;
      oe_r <= oe_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign link.scl = scl_r;
  assign link.ctl_sda_o = 1'b0;
  assign link.ctl_sda_oe = oe_r;
  assign rdata_o = rdata_r;

endmodule

// file: core/twe_dev.sv
// EEPROM target end: protocol engine, page buffer, array and program timer.
// Assumes the link pins are asynchronous to clk_i and are synchronised here.
`timescale 1ns/100ps

module twe_dev #(
  parameter int unsigned PROG_CYC = twe_pkg::PROG_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link
  twe_if.dev link,
  // User side
  input wire logic wp_i,
  output logic standby_o,
  output logic busy_o
);

  localparam int unsigned CW = $clog2(PROG_CYC + 1);
  localparam int unsigned AW = twe_pkg::ADDR_W;
  localparam int unsigned PW = twe_pkg::PAGE_W;

  if (PROG_CYC < 1) begin : g_chk
    $error("PROG_CYC must be at least one");
  end

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_DEV = 6'h02,
    ST_WAD = 6'h04,
    ST_WDT = 6'h08,
    ST_RD = 6'h10,
    ST_PROG = 6'h20
  } twe_st_e;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Stage 0 feeds only stage 1; stage 2 is history for edge finding
  logic [2:0] scl_s_r;
  logic [2:0] sda_s_r;
  logic [1:0] wp_s_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      wp_s_r <= 2'h0;
    end else begin
      scl_s_r <= {scl_s_r[1:0], link.scl};
      sda_s_r <= {sda_s_r[1:0], link.sda};
      wp_s_r <= {wp_s_r[0], wp_i};
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic sda_in;
  logic wp_in;

  assign sda_in = sda_s_r[1];
  assign wp_in = wp_s_r[1];
  assign scl_rise = scl_s_r[1] & ~scl_s_r[2];
  assign scl_fall = ~scl_s_r[1] & scl_s_r[2];
  // Data edges while the clock stays high are framing, never data
  assign start_det = scl_s_r[1] & scl_s_r[2] & sda_s_r[2] & ~sda_s_r[1];
  assign stop_det = scl_s_r[1] & scl_s_r[2] & ~sda_s_r[2] & sda_s_r[1];

  // ----------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------
  twe_st_e st_r, st_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic [2:0] pg_r, pg_nxt;
  logic rd_r, rd_nxt;
  logic mack_r, mack_nxt;
  logic oe_r, oe_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [twe_pkg::PAGE_BYTES-1:0] mask_r, mask_nxt;
  logic [7:0] buf_r [twe_pkg::PAGE_BYTES];
  logic [7:0] buf_nxt [twe_pkg::PAGE_BYTES];
  logic [7:0] mem_r [twe_pkg::DEPTH];
  logic [7:0] mem_nxt [twe_pkg::DEPTH];
  logic match;

  // Type code compare only; busy devices ignore the link, so address polling sees no ack
  assign match = (sh_r[7:4] == twe_pkg::DEV_TYPE);

  always_comb begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    addr_nxt = addr_r;
    pg_nxt = pg_r;
    rd_nxt = rd_r;
    mack_nxt = mack_r;
    oe_nxt = oe_r;
    cnt_nxt = cnt_r;
    mask_nxt = mask_r;
    buf_nxt = buf_r;
    mem_nxt = mem_r;
    if (st_r == ST_PROG) begin
      // Inputs are ignored until the program timer expires
      cnt_nxt = CW'(cnt_r + 1'b1);
      if (cnt_r == CW'(PROG_CYC - 1)) begin
        cnt_nxt = '0;
        st_nxt = ST_IDLE;
      end
    end else if (start_det) begin
      // A restart drops any unfinished page buffer
      st_nxt = ST_DEV;
      bit_nxt = 4'h0;
      oe_nxt = 1'b0;
      mask_nxt = '0;
    end else if (stop_det) begin
      oe_nxt = 1'b0;
      st_nxt = ST_IDLE;
      if (st_r == ST_WDT && (|mask_r) && !wp_in) begin
        for (int i = 0; i < twe_pkg::PAGE_BYTES; i++) begin
          if (mask_r[i]) begin
            mem_nxt[{addr_r[AW-1:PW], PW'(i)}] = buf_r[i];
          end
        end
        st_nxt = ST_PROG;
      end
      mask_nxt = '0;
    end else if (st_r != ST_IDLE) begin
      if (scl_rise) begin
        if (bit_r != twe_pkg::BIT_END) begin
          bit_nxt = bit_r + 4'h1;
        end
        if (bit_r < twe_pkg::BIT_ACK && st_r != ST_RD) begin
          sh_nxt = {sh_r[6:0], sda_in};
        end
        if (bit_r == twe_pkg::BIT_ACK && st_r == ST_RD) begin
          mack_nxt = ~sda_in;
        end
      end else if (scl_fall) begin
        if (bit_r == twe_pkg::BIT_ACK) begin
          // Ninth clock opens on this fall
          unique case (st_r)
            ST_DEV: begin
              if (match) begin
                oe_nxt = 1'b1;
                pg_nxt = sh_r[3:1];
                rd_nxt = sh_r[0];
              end else begin
                st_nxt = ST_IDLE;
              end
            end
            ST_WAD: begin
              oe_nxt = 1'b1;
            end
            ST_WDT: begin
              oe_nxt = 1'b1;
              buf_nxt[addr_r[PW-1:0]] = sh_r;
              mask_nxt[addr_r[PW-1:0]] = 1'b1;
              addr_nxt = {addr_r[AW-1:PW], PW'(addr_r[PW-1:0] + 1'b1)};
            end
            ST_RD: begin
              oe_nxt = 1'b0;
            end
            default: begin
              st_nxt = ST_IDLE;
            end
          endcase
        end else if (bit_r == twe_pkg::BIT_END) begin
          // Ninth clock closes: release and move on
          bit_nxt = 4'h0;
          oe_nxt = 1'b0;
          unique case (st_r)
            ST_DEV: begin
              if (rd_r) begin
                st_nxt = ST_RD;
                tx_nxt = mem_r[addr_r];
                oe_nxt = ~mem_r[addr_r][7];
                addr_nxt = AW'(addr_r + 1'b1);
              end else begin
                st_nxt = ST_WAD;
              end
            end
            ST_WAD: begin
              addr_nxt = {pg_r, sh_r};
              st_nxt = ST_WDT;
              mask_nxt = '0;
            end
            ST_WDT: begin
              st_nxt = ST_WDT;
            end
            ST_RD: begin
              if (mack_r) begin
                tx_nxt = mem_r[addr_r];
                oe_nxt = ~mem_r[addr_r][7];
                addr_nxt = AW'(addr_r + 1'b1);
              end else begin
                // Host declined; wait for its stop
                st_nxt = ST_IDLE;
              end
            end
            default: begin
              st_nxt = ST_IDLE;
            end
          endcase
        end else if (st_r == ST_RD) begin
          // Next data bit goes out only after the clock has fallen
          tx_nxt = {tx_r[6:0], 1'b0};
          oe_nxt = ~tx_r[6];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= ST_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      addr_r <= '0;
      pg_r <= 3'h0;
      rd_r <= 1'b0;
      mack_r <= 1'b0;
      oe_r <= 1'b0;
      cnt_r <= '0;
      mask_r <= '0;
      for (int i = 0; i < twe_pkg::PAGE_BYTES; i++) begin
        buf_r[i] <= 8'h00;
      end
      for (int i = 0; i < twe_pkg::DEPTH; i++) begin
        mem_r[i] <= 8'h00;
      end
    end else begin
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      addr_r <= addr_nxt;
      pg_r <= pg_nxt;
      rd_r <= rd_nxt;
      mack_r <= mack_nxt;
      oe_r <= oe_nxt;
      cnt_r <= cnt_nxt;
      mask_r <= mask_nxt;
      buf_r <= buf_nxt;
      mem_r <= mem_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open drain: only ever pulls low
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = oe_r;
  assign standby_o = (st_r == ST_IDLE);
  assign busy_o = (st_r == ST_PROG);

endmodule

// file: core/twe_if.sv
// Two-wire link between controller and EEPROM target.
// Assumes open-drain data with a pull-up, modelled from the drive enables.
`timescale 1ns/100ps

interface twe_if;
  logic scl;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // Wired-AND with pull-up: a released line reads high
  assign sda = (ctl_sda_oe ? ctl_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport ctl (output scl, input sda, output ctl_sda_o, output ctl_sda_oe);
endinterface

// file: core/twe_pkg.sv
// Constants shared by both ends of the two-wire EEPROM link.
// Assumes a single 200 MHz clock domain on each end; no import is used anywhere.
//
// Operation
// - Data changes only while clock low
// - Data falling, clock high: start
// - Data rising, clock high: stop, standby
// - Eight-bit words, device acks ninth clock
// - Standby at power-up and after stop
// - Recovery: start, nine clocks, start, stop
// - Address upper nibble must match type code
// - Next three bits are page bits
// - Eighth bit high reads, low writes
// - Match acks low; mismatch returns standby
// - Byte write: address, data, stop
// - Stop after write starts timed program
// - Page write up to sixteen bytes
// - Write address wraps inside page
// - No ack while programming runs
// - Counter holds last address plus one
// - Read address wraps over whole array
// - Current read: byte, no ack, stop
// - Random read: dummy write, restart, read
// - Acked read bytes continue sequentially
// - Sample on clock rise, drive after fall
// - Protect input high blocks all writes
// - 128 pages of 16 bytes, 11-bit address

package twe_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned PROG_TIME_MS = 5;
  localparam int unsigned PROG_CYC = CLK_HZ / 1000 * PROG_TIME_MS;
  localparam int unsigned SCL_KHZ = 400;
  localparam int unsigned QTR_CYC = CLK_HZ / (SCL_KHZ * 1000 * 4);

  // ----------------------------------------------------------------
  // Array organisation
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned DEPTH = 2048;
  localparam int unsigned PAGE_W = 4;
  localparam int unsigned PAGE_BYTES = 16;
  localparam logic [3:0] DEV_TYPE = 4'hA;

  // Bit counter landmarks within one nine-clock word
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;

  // ----------------------------------------------------------------
  // Controller register map and fields
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_CMD = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam int unsigned CMD_OP_LSB = 8;
  localparam int unsigned CMD_ACK_BIT = 10;
  localparam int unsigned STAT_BUSY_BIT = 8;
  localparam int unsigned STAT_ACK_BIT = 9;

  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_STOP = 2'h1,
    OP_WRITE = 2'h2,
    OP_READ = 2'h3
  } twe_op_e;

endpackage

// file: tb/twe_properties.sv
// Concurrent checks on the two-wire link and the target's status outputs.
// Assumes one clock domain; instantiated by the bench beside the link interface.
`timescale 1ns/100ps

module twe_properties #(
  parameter int unsigned PROG_CYC = 200
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  // Target status
  input wire logic standby_o,
  input wire logic busy_o
);
  int unsigned busy_cnt_r;
  int unsigned busy_cnt_nxt;

  // ---------------------------------------------------------------
  // Program time counter
  // ---------------------------------------------------------------
  always_comb begin
    busy_cnt_nxt = busy_o ? busy_cnt_r + 1 : 0;
  end

  always_ff @(posedge clk_i) begin
    busy_cnt_r <= rst_i ? 0 : busy_cnt_nxt;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  dev_drive_low_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("target data changed while clock high");
  prog_quiet_a: assert property (busy_o |-> !dev_sda_oe)
    else $error("target drove data during program time");
  reset_standby_a: assert property ($fell(rst_i) |-> standby_o && !busy_o)
    else $error("target not in standby after reset");
  prog_len_a: assert property ($fell(busy_o) |->
    busy_cnt_r >= PROG_CYC - 1 && busy_cnt_r <= PROG_CYC + 1)
    else $error("program time length wrong");
  prog_entry_a: assert property ($rose(busy_o) |-> scl && sda)
    else $error("program time began without a stop");
  prog_standby_a: assert property (busy_o |-> !standby_o)
    else $error("standby shown during program time");
  stop_standby_a: assert property (scl && $rose(sda) && !busy_o |->
    ##[1:8] (standby_o || busy_o))
    else $error("stop did not return target to standby");
  start_wake_a: assert property (scl && $fell(sda) && !busy_o |->
    ##[1:8] !standby_o)
    else $error("start not recognised");
endmodule

// file: tb/two_wire_eeprom_target_bench.sv
// Self-checking bench: controller end drives the target end over the link.
// Assumes short program time and quarter period parameters for run length.
`timescale 1ns/100ps

`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, a); end end

module two_wire_eeprom_target_bench;
  localparam int unsigned PROG = 2000;
  logic clk_i;
  logic rst_i;
  logic wp_i;
  logic standby_o;
  logic busy_o;
  logic [1:0] addr_i;
  logic [15:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [15:0] rdata_o;
  logic [15:0] st;
  logic [31:0] lfsr_q;
  logic [7:0] mem [0:2047];
  logic [10:0] ctr;
  logic [10:0] a;
  logic [7:0] r8;
  int fail_count;
  int samples_checked;

  twe_if link();
  twe_dev #(.PROG_CYC(PROG)) twe_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .wp_i(wp_i), .standby_o(standby_o), .busy_o(busy_o));
  twe_ctl #(.QTR_CYC(8)) twe_ctl_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
  twe_properties #(.PROG_CYC(PROG)) twe_properties_inst (.clk_i(clk_i), .rst_i(rst_i),
    .scl(link.scl), .sda(link.sda), .dev_sda_oe(link.dev_sda_oe),
    .standby_o(standby_o), .busy_o(busy_o));

  always #2.5 clk_i = ~clk_i;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] rnd();
    lfsr_q = {lfsr_q[30:0], 1'b0} ^ (lfsr_q[31] ? 32'h04C11DB7 : 32'h00000000);
    return lfsr_q[7:0];
  endfunction

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Register port: tasks start right after an edge and end right after one
  task automatic reg_wr(input logic [1:0] ad, input logic [15:0] d);
    addr_i <= ad;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe; take them mid-cycle
  task automatic reg_rd(input logic [1:0] ad);
    addr_i <= ad;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    st = rdata_o;
    @(posedge clk_i);
  endtask

  task automatic op(input logic [1:0] o, input logic [7:0] b, input logic ak);
    int n;
    reg_wr(twe_pkg::REG_CMD, {5'h00, ak, o, b});
    n = 0;
    do begin
      reg_rd(twe_pkg::REG_STAT);
      n++;
    end while (st[8] !== 1'b0 && n < 5000);
    if (n >= 5000) begin
      fail_count++;
      conclude();
    end
  endtask

  task automatic dev_word(input logic [2:0] pg, input logic dir);
    op(twe_pkg::OP_WRITE, {twe_pkg::DEV_TYPE, pg, dir}, 1'b0);
    `CHK("address ack", 1'b1, st[9])
  endtask

  task automatic wr_seq(input logic [10:0] wa, input int n, input logic prot);
    logic [7:0] d;
    wp_i <= prot;
    op(twe_pkg::OP_START, 8'h00, 1'b0);
    dev_word(wa[10:8], 1'b0);
    op(twe_pkg::OP_WRITE, wa[7:0], 1'b0);
    `CHK("word address ack", 1'b1, st[9])
    for (int i = 0; i < n; i++) begin
      d = rnd();
      op(twe_pkg::OP_WRITE, d, 1'b0);
      `CHK("data ack", 1'b1, st[9])
      if (!prot) mem[{wa[10:4], wa[3:0] + i[3:0]}] = d;
    end
    op(twe_pkg::OP_STOP, 8'h00, 1'b0);
  endtask

  // Acknowledge polling after a write that must start program time
  task automatic poll();
    int n;
    n = 0;
    while (busy_o !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    `CHK("program time", 1'b1, busy_o)
    if (busy_o !== 1'b1) conclude();
    @(posedge clk_i);
    n = 0;
    do begin
      op(twe_pkg::OP_START, 8'h00, 1'b0);
      op(twe_pkg::OP_WRITE, {twe_pkg::DEV_TYPE, 3'h0, 1'b0}, 1'b0);
      if (n == 0) `CHK("ack while busy", 1'b0, st[9])
      n++;
    end while (st[9] !== 1'b1 && n < 40);
    `CHK("ack after program", 1'b1, st[9])
    if (st[9] !== 1'b1) conclude();
    op(twe_pkg::OP_STOP, 8'h00, 1'b0);
  endtask

  task automatic rd_seq(input logic [10:0] ra, input int n, input logic load);
    if (load) begin
      op(twe_pkg::OP_START, 8'h00, 1'b0);
      dev_word(ra[10:8], 1'b0);
      op(twe_pkg::OP_WRITE, ra[7:0], 1'b0);
      ctr = ra;
    end
    op(twe_pkg::OP_START, 8'h00, 1'b0);
    dev_word(3'h0, 1'b1);
    for (int i = 0; i < n; i++) begin
      op(twe_pkg::OP_READ, 8'h00, i < n - 1);
      `CHK("read data", mem[ctr], st[7:0])
      ctr = ctr + 11'h001;
    end
    op(twe_pkg::OP_STOP, 8'h00, 1'b0);
    repeat (10) @(negedge clk_i);
    `CHK("standby after read", 1'b1, standby_o)
    @(posedge clk_i);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    wp_i = 1'b0;
    addr_i = 2'h0;
    wdata_i = 16'h0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    lfsr_q = 32'hA8E26CD2;
    fail_count = 0;
    samples_checked = 0;
    ctr = 11'h000;
    for (int i = 0; i < 2048; i++) mem[i] = 8'h00;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(negedge clk_i);
    `CHK("standby at reset", 1'b1, standby_o)
    `CHK("idle data line", 1'b1, link.sda)
    @(posedge clk_i);
    // Protocol recovery
    op(twe_pkg::OP_START, 8'h00, 1'b0);
    op(twe_pkg::OP_READ, 8'h00, 1'b0);
    op(twe_pkg::OP_START, 8'h00, 1'b0);
    op(twe_pkg::OP_STOP, 8'h00, 1'b0);
    // Foreign device type is left unacknowledged
    op(twe_pkg::OP_START, 8'h00, 1'b0);
    r8 = rnd();
    op(twe_pkg::OP_WRITE, {((r8[7:4] == twe_pkg::DEV_TYPE) ? 4'h5 : r8[7:4]), r8[3:1], 1'b0},
      1'b0);
    `CHK("foreign type ack", 1'b0, st[9])
    op(twe_pkg::OP_STOP, 8'h00, 1'b0);
    // Page write past the page end overwrites its start
    r8 = rnd();
    a = {r8[2:0], rnd()};
    wr_seq(a, 18, 1'b0);
    poll();
    rd_seq({a[10:4], 4'h0}, 17, 1'b1);
    rd_seq(11'h000, 1, 1'b0);
    // Single byte write, then protected write to the same place.
    // Same offset in another page, so ignored page bits would clobber the page write.
    a = a ^ 11'h400;
    wr_seq(a, 1, 1'b0);
    poll();
    wr_seq(a, 1, 1'b1);
    repeat (20) @(negedge clk_i);
    `CHK("no program when protected", 1'b0, busy_o)
    @(posedge clk_i);
    rd_seq(a, 1, 1'b1);
    rd_seq(a ^ 11'h400, 1, 1'b1);
    // Read roll-over at the array end
    rd_seq(11'h7FF, 3, 1'b1);
    conclude();
  end
endmodule
